// file: mbw_checker.sv
// mbw_checker: port assertions for the block-write interpreter
`timescale 1ns/100ps
`default_nettype none
module mbw_checker (
    input wire logic        i_core_clk,    // core clock
    input wire logic        i_rst,         // sync reset
    input wire logic [7:0]  i_node_addr,   // own address
    input wire logic        i_rx_eof,      // frame end
    input wire logic        i_tx_ready,    // transmitter ready
    input wire logic        i_node_busy,   // busy level
    input wire logic        o_tx_valid,    // reply valid
    input wire logic [7:0]  o_tx_byte,     // reply byte
    input wire logic        o_tx_last,     // reply last
    input wire logic        o_time_we,     // time written
    input wire logic [63:0] o_system_time, // time value
    input wire logic [7:0]  o_year,        // year
    input wire logic [7:0]  o_second,      // second
    input wire logic [15:0] o_subsecond    // sub-second
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    tx_hold_a: assert property (
        o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
        else $error("reply byte changed before taken");
    last_drop_a: assert property (
        o_tx_valid && i_tx_ready && o_tx_last |=> !o_tx_valid) else $error("reply ran past crc high byte");
    we_pulse_a: assert property (
        o_time_we |=> !o_time_we) else $error("write pulse longer than one cycle");
    we_eof_a: assert property (
        o_time_we |-> $past(i_rx_eof, 2)) else $error("write pulse not two cycles after frame end");
    busy_nowrite_a: assert property (
        o_time_we |-> !$past(i_node_busy)) else $error("time written while busy");
    time_slices_a: assert property (
        o_year == o_system_time[63:56] && o_second == o_system_time[23:16] && o_subsecond == o_system_time[15:0])
        else $error("time fields disagree with time value");
    reply_addr_a: assert property (
        i_rx_eof ##3 o_tx_valid |-> o_tx_byte == i_node_addr) else $error("reply does not start with own address");
    time_cause_a: assert property (
        $changed(o_system_time) |-> o_time_we || $past(o_time_we)) else $error("time changed without a write");

    // main scenarios reached
    cover property (o_time_we);
    cover property (o_tx_valid && i_tx_ready && o_tx_last);
    cover property (o_tx_valid && o_tx_byte == 8'h90);
endmodule : mbw_checker
`default_nettype wire

bind mbw_frame mbw_checker chk (.i_core_clk, .i_rst, .i_node_addr, .i_rx_eof, .i_tx_ready, .i_node_busy,
    .o_tx_valid, .o_tx_byte, .o_tx_last, .o_time_we, .o_system_time, .o_year, .o_second, .o_subsecond);

// file: mbw_crc16.sv
// mbw_crc16: byte-wide modbus crc-16 accumulator
`timescale 1ns/100ps
`default_nettype none
module mbw_crc16 (
    input  wire logic        i_core_clk, // core clock
    input  wire logic        i_rst,      // sync reset, high
    input  wire logic        i_clear,    // restart at init value
    input  wire logic        i_valid,    // byte strobe
    input  wire logic [7:0]  i_byte,     // byte to fold in
    output logic      [15:0] o_crc       // running crc
);
    typedef struct packed {
        logic [15:0] crc;
    } mbw_crc_st_t;

    mbw_crc_st_t st_r;
    mbw_crc_st_t st_nxt;

    // reflected lsb-first update, one byte per strobe
    always_comb begin
        logic [15:0] c;
        c = st_r.crc;
        st_nxt = st_r;
        if (i_clear) begin
            st_nxt.crc = mbw_pkg::CRC_INIT;
        end else if (i_valid) begin
            c = c ^ {8'h00, i_byte};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ mbw_pkg::CRC_POLY) : (c >> 1);
            end
            st_nxt.crc = c;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r <= '{crc: mbw_pkg::CRC_INIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_crc = st_r.crc;
endmodule : mbw_crc16
`default_nettype wire

// file: mbw_frame.sv
// mbw_frame: modbus rtu slave interpreter for write-multiple-registers
`timescale 1ns/100ps
`default_nettype none
module mbw_frame (
    input  wire logic        i_core_clk,     // core clock, 200 mhz
    input  wire logic        i_rst,          // sync reset, high
    input  wire logic [7:0]  i_node_addr,    // own node address, pin strap
    input  wire logic        i_rx_valid,     // received byte strobe
    input  wire logic [7:0]  i_rx_byte,      // received byte
    input  wire logic        i_rx_par_err,   // parity error on this byte
    input  wire logic        i_rx_eof,       // frame gap seen, frame ends
    input  wire logic        i_tx_ready,     // transmitter takes a byte
    input  wire logic        i_node_busy,    // previous work still pending
    input  wire logic        i_slow_write,   // write needs extended time
    input  wire logic        i_store_fail,   // value buffer write failed
    output logic             o_tx_valid,     // reply byte offered
    output logic      [7:0]  o_tx_byte,      // reply byte
    output logic             o_tx_last,      // last byte of reply
    output logic             o_time_we,      // system time updated, pulse
    output logic      [63:0] o_system_time,  // breaker_system_time value
    output logic      [7:0]  o_year,         // time: year
    output logic      [7:0]  o_month,        // time: month
    output logic      [7:0]  o_day,          // time: day
    output logic      [7:0]  o_hour,         // time: hour
    output logic      [7:0]  o_minute,       // time: minute
    output logic      [7:0]  o_second,       // time: second
    output logic      [15:0] o_subsecond     // time: sub-second
);
    typedef enum logic [2:0] {
        ST_RX   = 3'b000,
        ST_SKIP = 3'b001,
        ST_EVAL = 3'b010,
        ST_TX   = 3'b011,
        ST_CRC  = 3'b100
    } mbw_state_t;

    typedef struct packed {
        mbw_state_t  state;
        logic [4:0]  idx;        // bytes received in frame
        logic        bad;        // parity or overrun seen
        logic [7:0]  addr;
        logic [7:0]  fc;
        logic [15:0] start;
        logic [15:0] count;
        logic [7:0]  nbytes;
        logic [63:0] data;
        logic [7:0]  crc_lo;     // last two bytes, the crc
        logic [7:0]  crc_hi;
        logic [15:0] crc_prev;   // crc before the last byte; crc_prev2 before the last two
        logic [15:0] crc_prev2;
        logic [3:0]  tx_len;
        logic [3:0]  tx_pos;
        logic [63:0] tx_buf;
        logic        tx_valid;
        logic [7:0]  tx_byte;
        logic        tx_last;
        logic        crc_hi_sent;
        logic        time_we;
        logic [63:0] systime;
    } mbw_st_t;

    mbw_st_t     st_r;
    mbw_st_t     st_nxt;
    logic [7:0]  node_addr_s;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic        tx_clr;
    logic        tx_fold;

    // strap crosses in from a pin
    mbw_sync2 #(.W(8)) u_addr_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (i_node_addr),
        .o_sync     (node_addr_s)
    );

    // receive crc over every byte; the trailing two are compared later
    mbw_crc16 u_rx_crc (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clear    (st_r.state == ST_EVAL),
        .i_valid    (i_rx_valid && st_r.state == ST_RX),
        .i_byte     (i_rx_byte),
        .o_crc      (rx_crc)
    );

    // transmit crc folds each reply byte ahead of the crc trailer as it is accepted
    mbw_crc16 u_tx_crc (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clear    (tx_clr),
        .i_valid    (tx_fold),
        .i_byte     (st_r.tx_byte),
        .o_crc      (tx_crc)
    );

    assign tx_clr  = (st_r.state == ST_EVAL);
    assign tx_fold = st_r.tx_valid && i_tx_ready && (st_r.state == ST_TX);

    // byte-lane pick from the reply buffer, msb byte first
    function automatic logic [7:0] pick(input logic [63:0] buf_v, input logic [3:0] pos);
        pick = buf_v[63 - 8*pos -: 8];
    endfunction

    // frame walker, evaluation and reply sequencer
    always_comb begin
        logic        ok_crc;
        logic        mine;
        logic        bcast;
        logic [7:0]  exc;
        logic        do_write;
        ok_crc   = 1'b0;
        mine     = 1'b0;
        bcast    = 1'b0;
        exc      = 8'h00;
        do_write = 1'b0;
        st_nxt   = st_r;
        st_nxt.time_we = 1'b0;
        case (st_r.state)
            ST_RX: begin
                if (i_rx_valid) begin
                    if (i_rx_par_err) begin
                        st_nxt.bad = 1'b1;
                    end
                    // field order on the wire
                    case (st_r.idx)
                        5'd0: st_nxt.addr = i_rx_byte;
                        5'd1: st_nxt.fc = i_rx_byte;
                        5'd2: st_nxt.start[15:8] = i_rx_byte;
                        5'd3: st_nxt.start[7:0] = i_rx_byte;
                        5'd4: st_nxt.count[15:8] = i_rx_byte;
                        5'd5: st_nxt.count[7:0] = i_rx_byte;
                        5'd6: st_nxt.nbytes = i_rx_byte;
                        default: begin
                            if (st_r.idx < 5'd15) begin
                                st_nxt.data[63 - 8*(st_r.idx - 5'd7) -: 8] = i_rx_byte;
                            end
                        end
                    endcase
                    // two-byte delay line of crc values and bytes
                    st_nxt.crc_prev2 = st_r.crc_prev;
                    st_nxt.crc_prev  = rx_crc;
                    st_nxt.crc_lo    = st_r.crc_hi;
                    st_nxt.crc_hi    = i_rx_byte;
                    if (st_r.idx == 5'd31) begin
                        st_nxt.bad = 1'b1; // overrun: frame longer than any we serve
                    end else begin
                        st_nxt.idx = st_r.idx + 5'd1;
                    end
                end
                if (i_rx_eof) begin
                    st_nxt.state = ST_EVAL;
                end
            end
            ST_EVAL: begin
                // crc covers all bytes before the trailing pair, low byte first
                ok_crc = (st_r.idx >= 5'd4) && !st_r.bad
                         && ({st_r.crc_hi, st_r.crc_lo} == st_r.crc_prev2);
                bcast  = (st_r.addr == mbw_pkg::ADDR_BROADCAST);
                mine   = (st_r.addr == node_addr_s);
                if (st_r.fc != mbw_pkg::FC_WRITE_MULTI) begin
                    exc = mbw_pkg::EXC_ILL_FUNC;
                end else if (i_node_busy) begin
                    exc = mbw_pkg::EXC_BUSY;
                end else if (st_r.start != {mbw_pkg::TIME_START_HI, mbw_pkg::TIME_START_LO}) begin
                    exc = mbw_pkg::EXC_ILL_ADDR;
                end else if (st_r.count != mbw_pkg::TIME_REG_COUNT
                             || {8'h00, st_r.nbytes} != {st_r.count[14:0], 1'b0}
                             || st_r.idx != 5'd17) begin
                    exc = mbw_pkg::EXC_ILL_VALUE;
                end else if (i_store_fail) begin
                    exc = mbw_pkg::EXC_NODE_ERR;
                end else begin
                    do_write = 1'b1;
                    if (i_slow_write) begin
                        exc = mbw_pkg::EXC_CONFIRM;
                    end
                end
                st_nxt.idx = 5'd0;
                st_nxt.bad = 1'b0;
                st_nxt.state = ST_SKIP;
                if (ok_crc && (mine || bcast)) begin
                    if (do_write) begin
                        // year..second then sub-second
                        st_nxt.systime = st_r.data;
                        st_nxt.time_we = 1'b1;
                    end
                    if (!bcast) begin
                        st_nxt.state = ST_TX;
                        st_nxt.tx_pos = 4'd0;
                        if (exc != 8'h00) begin
                            st_nxt.tx_buf = {st_r.addr, st_r.fc | mbw_pkg::FC_EXC_FLAG, exc, 40'h0};
                            st_nxt.tx_len = 4'd3;
                        end else begin
                            st_nxt.tx_buf = {st_r.addr, st_r.fc, st_r.start, st_r.count, 16'h0};
                            st_nxt.tx_len = 4'd6;
                        end
                    end
                end
            end
            ST_SKIP: begin
                // one cycle for crc units to settle before the next frame
                st_nxt.tx_valid = 1'b0;
                st_nxt.tx_last  = 1'b0;
                st_nxt.crc_hi_sent = 1'b0;
                st_nxt.state = ST_RX;
            end
            ST_TX: begin
                if (!st_r.tx_valid) begin
                    st_nxt.tx_valid = 1'b1;
                    st_nxt.tx_byte  = pick(st_r.tx_buf, st_r.tx_pos);
                end else if (i_tx_ready) begin
                    if (st_r.tx_pos + 4'd1 == st_r.tx_len) begin
                        st_nxt.tx_valid = 1'b0;
                        st_nxt.state = ST_CRC;
                    end else begin
                        st_nxt.tx_pos  = st_r.tx_pos + 4'd1;
                        st_nxt.tx_byte = pick(st_r.tx_buf, st_r.tx_pos + 4'd1);
                    end
                end
            end
            ST_CRC: begin
                // crc trailer, low byte then high
                if (!st_r.tx_valid) begin
                    st_nxt.tx_valid = 1'b1;
                    st_nxt.tx_byte  = st_r.crc_hi_sent ? tx_crc[15:8] : tx_crc[7:0];
                    st_nxt.tx_last  = st_r.crc_hi_sent;
                end else if (i_tx_ready) begin
                    st_nxt.tx_valid = 1'b0;
                    st_nxt.tx_last  = 1'b0;
                    if (st_r.crc_hi_sent) begin
                        st_nxt.crc_hi_sent = 1'b0;
                        st_nxt.state = ST_RX;
                    end else begin
                        st_nxt.crc_hi_sent = 1'b1;
                    end
                end
            end
            default: st_nxt.state = ST_RX;
        endcase
    end

    // single state register; bytes arriving mid-reply are not taken
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.state <= ST_RX;
            st_r.systime <= mbw_pkg::TIME_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_tx_valid    = st_r.tx_valid;
    assign o_tx_byte     = st_r.tx_byte;
    assign o_tx_last     = st_r.tx_last;
    assign o_time_we     = st_r.time_we;
    assign o_system_time = st_r.systime;
    assign o_year        = st_r.systime[63:56];
    assign o_month       = st_r.systime[55:48];
    assign o_day         = st_r.systime[47:40];
    assign o_hour        = st_r.systime[39:32];
    assign o_minute      = st_r.systime[31:24];
    assign o_second      = st_r.systime[23:16];
    assign o_subsecond   = st_r.systime[15:0];
endmodule : mbw_frame
`default_nettype wire

// file: mbw_master_model.sv
// mbw_master_model: modbus master that sends requests and takes replies
`timescale 1ns/100ps
`default_nettype none
module mbw_master_model (
    input  wire logic       i_core_clk,   // core clock
    input  wire logic       i_tx_valid,   // reply byte offered
    input  wire logic [7:0] i_tx_byte,    // reply byte
    input  wire logic       i_tx_last,    // last reply byte
    output logic            o_rx_valid,   // request byte strobe
    output logic      [7:0] o_rx_byte,    // request byte
    output logic            o_rx_par_err, // parity flag
    output logic            o_rx_eof,     // frame gap
    output logic            o_tx_ready    // reply byte taken
);
    logic [7:0] rep[$];
    int         last_ix = -1;
    bit         slow = 1'b0;
    int         cnt = 0;

    initial begin
        o_rx_valid = 1'b0;
        o_rx_byte = 8'h00;
        o_rx_par_err = 1'b0;
        o_rx_eof = 1'b0;
        o_tx_ready = 1'b1;
    end

    // own crc so that a shared slip cannot hide
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = mbw_pkg::CRC_INIT;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ mbw_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc16

    // request bytes two cycles apart; bad flips the crc, par marks byte 3
    task automatic send(input logic [7:0] f[$], input bit bad, input bit par);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        rep.delete();
        last_ix = -1;
        foreach (f[i]) begin
            @(posedge i_core_clk);
            o_rx_valid <= 1'b1;
            o_rx_byte <= f[i];
            o_rx_par_err <= par && i == 3;
            @(posedge i_core_clk);
            o_rx_valid <= 1'b0;
            o_rx_byte <= ~f[i];
            o_rx_par_err <= 1'b0;
        end
        o_rx_eof <= 1'b1;
        @(posedge i_core_clk);
        o_rx_eof <= 1'b0;
    endtask : send

    // slow mode takes a byte only one cycle in four, to stall the reply
    always @(posedge i_core_clk) begin
        cnt++;
        if (i_tx_valid && o_tx_ready) begin
            rep.push_back(i_tx_byte);
            if (i_tx_last) last_ix = rep.size();
        end
        o_tx_ready <= !slow || cnt[1:0] == 2'd0;
    end
endmodule : mbw_master_model
`default_nettype wire

// file: mbw_pkg.sv
// mbw_pkg: constants for the modbus block-write frame interpreter
package mbw_pkg;
    localparam logic [7:0]  FC_WRITE_MULTI  = 8'h10;
    localparam logic [7:0]  FC_EXC_FLAG     = 8'h80;
    localparam logic [7:0]  ADDR_BROADCAST  = 8'h00;
    localparam logic [7:0]  TIME_START_HI   = 8'h44;
    localparam logic [7:0]  TIME_START_LO   = 8'h02;
    localparam logic [15:0] TIME_REG_COUNT  = 16'h0004;
    localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
    localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;
    localparam logic [7:0]  EXC_NODE_ERR    = 8'h04;
    localparam logic [7:0]  EXC_CONFIRM     = 8'h05;
    localparam logic [7:0]  EXC_BUSY        = 8'h06;
    localparam logic [15:0] CRC_INIT        = 16'hffff;
    localparam logic [15:0] CRC_POLY        = 16'ha001;
    localparam logic [63:0] TIME_RESET      = 64'h0000_0000_0000_0000;
    localparam int          MAX_DATA_BYTES  = 8;
    localparam int          MAX_REPLY_BYTES = 8;
endpackage : mbw_pkg

// file: mbw_sync2.sv
// mbw_sync2: two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module mbw_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk, // core clock
    input  wire logic         i_rst,      // sync reset, high
    input  wire logic [W-1:0] i_async,    // asynchronous level
    output logic      [W-1:0] o_sync      // synchronised level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mbw_sync_st_t;

    mbw_sync_st_t st_r;
    mbw_sync_st_t st_nxt;

    // first stage is only read by the second
    always_comb begin
        st_nxt.s1 = i_async;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.s2;
endmodule : mbw_sync2
`default_nettype wire

// file: tb.sv
// tb: self-checking bench for the block-write interpreter
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk, rst, busy, slw, fail, rxv, rxp, eof, rdy, txv, txl, we;
    logic [7:0]  node, rxb, txb, yr, mon, dy, hr, mnt, sec;
    logic [15:0] subs;
    logic [63:0] stime;
    logic [7:0]  none[$];
    logic [7:0]  hdr[$] = '{8'h07, 8'h10, 8'h44, 8'h02, 8'h00, 8'h04};
    logic [7:0]  dat[$] = '{8'h08, 8'h09, 8'h05, 8'h27, 8'h11, 8'h15, 8'h30, 8'h00, 8'h04};
    int          num_errors = 0;
    int          n_compared = 0;
    int          we_cnt = 0;

    mbw_frame uut (.i_core_clk(clk), .i_rst(rst), .i_node_addr(node), .i_rx_valid(rxv), .i_rx_byte(rxb),
        .i_rx_par_err(rxp), .i_rx_eof(eof), .i_tx_ready(rdy), .i_node_busy(busy), .i_slow_write(slw),
        .i_store_fail(fail), .o_tx_valid(txv), .o_tx_byte(txb), .o_tx_last(txl), .o_time_we(we),
        .o_system_time(stime), .o_year(yr), .o_month(mon), .o_day(dy), .o_hour(hr), .o_minute(mnt),
        .o_second(sec), .o_subsecond(subs));
    mbw_master_model m (.i_core_clk(clk), .i_tx_valid(txv), .i_tx_byte(txb), .i_tx_last(txl),
        .o_rx_valid(rxv), .o_rx_byte(rxb), .o_rx_par_err(rxp), .o_rx_eof(eof), .o_tx_ready(rdy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // count write pulses seen
    always @(posedge clk) if (we === 1'b1) we_cnt++;

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // one request and its reply; an empty r means silence expected
    task automatic xact(input logic [7:0] f[$], input logic [7:0] r[$], input bit bad, input bit par);
        logic [15:0] c;
        int          k;
        m.send(f, bad, par);
        k = 0;
        while (m.last_ix < 0 && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (r.size() == 0) begin
            cmp("silent reply length", 64'd0, 64'(m.rep.size()));
            return;
        end
        if (k == 400) begin
            num_errors++;
            $display("[ERR] reply wait expected last byte seen none");
            tally_and_finish;
        end
        c = m.crc16(r);
        r.push_back(c[7:0]);
        r.push_back(c[15:8]);
        cmp("reply length", 64'(r.size()), 64'(m.rep.size()));
        cmp("last flag index", 64'(r.size()), 64'(m.last_ix));
        foreach (r[i]) cmp("reply byte", {56'h0, r[i]}, {56'h0, m.rep[i]});
        repeat (2) @(posedge clk);
    endtask : xact

    task automatic t_write;
        logic [7:0] f[$];
        f = {hdr, dat};
        m.slow = 1'b1;
        we_cnt = 0;
        xact(f, hdr, 1'b0, 1'b0);
        m.slow = 1'b0;
        cmp("time value", 64'h0905_2711_1530_0004, stime);
        cmp("time fields", 64'h0905_2711_1530_0004, {yr, mon, dy, hr, mnt, sec, subs});
        cmp("write pulses", 64'd1, 64'(we_cnt));
        $display("write test done");
    endtask : t_write

    task automatic t_bcast;
        logic [7:0] f[$];
        f = {hdr, dat};
        f[0] = mbw_pkg::ADDR_BROADCAST;
        f[7] = 8'h0a;
        we_cnt = 0;
        xact(f, none, 1'b0, 1'b0);
        cmp("broadcast pulses", 64'd1, 64'(we_cnt));
        cmp("broadcast year", 64'h0a, {56'h0, yr});
        $display("broadcast test done");
    endtask : t_bcast

    // bad crc, parity error, foreign address: all silent, no write
    task automatic t_drop;
        logic [7:0] f[$];
        f = {hdr, dat};
        f[7] = 8'h33;
        we_cnt = 0;
        xact(f, none, 1'b1, 1'b0);
        xact(f, none, 1'b0, 1'b1);
        f[0] = 8'h08;
        xact(f, none, 1'b0, 1'b0);
        cmp("dropped pulses", 64'd0, 64'(we_cnt));
        cmp("year kept", 64'h0a, {56'h0, yr});
        $display("drop test done");
    endtask : t_drop

    // every exception code, in the priority order the design uses
    task automatic t_exc;
        logic [7:0] f[$];
        logic [7:0] r[$];
        logic [7:0] code[6];
        code = '{mbw_pkg::EXC_ILL_FUNC, mbw_pkg::EXC_BUSY, mbw_pkg::EXC_ILL_ADDR, mbw_pkg::EXC_ILL_VALUE,
            mbw_pkg::EXC_NODE_ERR, mbw_pkg::EXC_CONFIRM};
        for (int i = 0; i < 6; i++) begin
            f = {hdr, dat};
            if (i == 0) f[1] = 8'h03;
            if (i == 2) f[3] = 8'h03;
            if (i == 3) f[6] = 8'h0a;
            busy <= (i == 1);
            fail <= (i == 4);
            slw <= (i == 5);
            r = '{8'h07, f[1] | mbw_pkg::FC_EXC_FLAG, code[i]};
            we_cnt = 0;
            xact(f, r, 1'b0, 1'b0);
            if (i == 1 || i == 5) cmp("exception write pulses", 64'(i == 5), 64'(we_cnt));
        end
        busy <= 1'b0;
        fail <= 1'b0;
        slw <= 1'b0;
        $display("exception test done");
    endtask : t_exc

    initial begin
        rst = 1'b1;
        node = 8'h07;
        busy = 1'b0;
        slw = 1'b0;
        fail = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        cmp("reset time", mbw_pkg::TIME_RESET, stime);
        t_write;
        t_bcast;
        t_drop;
        t_exc;
        tally_and_finish;
    end
endmodule : tb
`default_nettype wire
